// [rtl/oag_pkg.sv]
// package: address constants, mode codes and register indices for the operand address unit
package oag_pkg;
	localparam logic [15:0] SHORT_LO = 16'hfe80;
	localparam logic [15:0] SHORT_HI = 16'hff1f;
	localparam logic [6:0] SHORT_TOP = 7'h7f;
	localparam logic [7:0] SHORT_SFR_MAX = 8'h1f;
	localparam logic [7:0] SHORT_RAM_MIN = 8'h80;
	localparam int SHORT_BIT8 = 8;
	localparam logic [7:0] SFR_PAGE = 8'hff;
	localparam logic [15:0] ZERO_ADDR = 16'h0000;
	// absolute byte register indices
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_C = 3'h2;
	localparam logic [2:0] REG_B = 3'h3;
	localparam logic [2:0] REG_E = 3'h4;
	localparam logic [2:0] REG_D = 3'h5;
	localparam logic [2:0] REG_L = 3'h6;
	localparam logic [2:0] REG_H = 3'h7;
	// register pair indices
	localparam logic [1:0] PAIR_AX = 2'h0;
	localparam logic [1:0] PAIR_BC = 2'h1;
	localparam logic [1:0] PAIR_DE = 2'h2;
	localparam logic [1:0] PAIR_HL = 2'h3;
	// pointer select code for register indirect
	localparam logic sel_second = 1'b0;
	localparam logic sel_base = 1'b1;
	typedef enum logic [2:0] {
		OAG_MODE_NONE,
		OAG_MODE_DIRECT,
		OAG_MODE_SHORT,
		OAG_MODE_SFR,
		OAG_MODE_REG,
		OAG_MODE_INDIRECT,
		OAG_MODE_BASED,
		OAG_MODE_STACK
	} oag_mode_t;
endpackage

// [rtl/oag_short_map.sv]
// short direct field to effective address mapper
module oag_short_map (
	input wire logic [7:0] field,
	output logic [15:0] addr,
	output logic in_window
);
	logic bit8;
	always_comb begin
		// 00h-1fh lands in the register page, 80h-ffh in fast ram
		bit8 = (field <= oag_pkg::SHORT_SFR_MAX);
		// 20h-7fh has no home in the window and is flagged unused
		in_window = bit8 || (field >= oag_pkg::SHORT_RAM_MIN);
		addr = {oag_pkg::SHORT_TOP, bit8, field};
	end
endmodule

// [rtl/oag_top.sv]
// operand address generator: effective address and register selection
//
// Summary of operation
// - direct mode uses full 16-bit immediate unchanged
// - short direct reaches only fe80h to ff1fh
// - field 80h-ffh clears bit 8, 00h-1fh sets
// - special register field selects within ff00h page
// - 3-bit code picks one of eight registers
// - x,a,c,b,e,d,l,h map 0-7; pairs 0-3
// - indirect uses second or base pointer pair
// - based adds zero-extended offset, carry dropped
// - stack pointer addressing for stack operations
module oag_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire oag_pkg::oag_mode_t op_mode,
	input wire logic [15:0] full_address_operand,
	input wire logic [7:0] op_byte,
	input wire logic [2:0] reg_code,
	input wire logic [1:0] register_pair_operand,
	input wire logic ptr_sel,
	input wire logic pair_form,
	input wire logic stack_op,
	input wire logic [15:0] second_pointer_pair,
	input wire logic [15:0] base_pointer_pair,
	input wire logic [15:0] stack_pointer,
	output logic ea_valid,
	output logic [15:0] ea,
	output logic mem_access,
	output logic reg_valid,
	output logic [2:0] reg_index,
	output logic [1:0] pair_index,
	output logic pair_access,
	output logic short_unused
);
	////////////////////////////////////////////////////////////////////
	logic [15:0] short_addr;
	logic short_ok;
	logic [15:0] based_sum;
	logic ea_valid_r, ea_valid_nxt;
	logic [15:0] ea_r, ea_nxt;
	logic mem_access_r, mem_access_nxt;
	logic reg_valid_r, reg_valid_nxt;
	logic [2:0] reg_index_r, reg_index_nxt;
	logic [1:0] pair_index_r, pair_index_nxt;
	logic pair_access_r, pair_access_nxt;
	logic short_unused_r, short_unused_nxt;

	oag_short_map u_short (
		.field(op_byte),
		.addr(short_addr),
		.in_window(short_ok)
	);

	// carry out of bit 15 is simply not kept
	assign based_sum = base_pointer_pair + {8'h00, op_byte};

	////////////////////////////////////////////////////////////////////
	always_comb begin
		ea_valid_nxt = 1'b0;
		ea_nxt = ea_r;
		mem_access_nxt = 1'b0;
		reg_valid_nxt = 1'b0;
		reg_index_nxt = reg_index_r;
		pair_index_nxt = pair_index_r;
		pair_access_nxt = 1'b0;
		short_unused_nxt = 1'b0;
		if (stack_op) begin
			// stack traffic overrides decoded operand mode
			ea_valid_nxt = 1'b1;
			mem_access_nxt = 1'b1;
			ea_nxt = stack_pointer;
		end else if (op_valid) begin
			case (op_mode)
				oag_pkg::OAG_MODE_DIRECT: begin
					ea_valid_nxt = 1'b1;
					mem_access_nxt = 1'b1;
					ea_nxt = full_address_operand;
				end
				oag_pkg::OAG_MODE_SHORT: begin
					// unused fields give no access at all
					ea_valid_nxt = short_ok;
					mem_access_nxt = short_ok;
					short_unused_nxt = !short_ok;
					ea_nxt = short_addr;
				end
				oag_pkg::OAG_MODE_SFR: begin
					ea_valid_nxt = 1'b1;
					mem_access_nxt = 1'b1;
					ea_nxt = {oag_pkg::SFR_PAGE, op_byte};
				end
				oag_pkg::OAG_MODE_REG: begin
					reg_valid_nxt = 1'b1;
					pair_access_nxt = pair_form;
					reg_index_nxt = reg_code;
					pair_index_nxt = register_pair_operand;
				end
				oag_pkg::OAG_MODE_INDIRECT: begin
					ea_valid_nxt = 1'b1;
					mem_access_nxt = 1'b1;
					if (ptr_sel == oag_pkg::sel_base)
						ea_nxt = base_pointer_pair;
					else
						ea_nxt = second_pointer_pair;
				end
				oag_pkg::OAG_MODE_BASED: begin
					ea_valid_nxt = 1'b1;
					mem_access_nxt = 1'b1;
					ea_nxt = based_sum;
				end
				oag_pkg::OAG_MODE_STACK: begin
					ea_valid_nxt = 1'b1;
					mem_access_nxt = 1'b1;
					ea_nxt = stack_pointer;
				end
				default: begin
					ea_valid_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ea_valid_r <= 1'b0;
			ea_r <= oag_pkg::ZERO_ADDR;
			mem_access_r <= 1'b0;
			reg_valid_r <= 1'b0;
			reg_index_r <= oag_pkg::REG_X;
			pair_index_r <= oag_pkg::PAIR_AX;
			pair_access_r <= 1'b0;
			short_unused_r <= 1'b0;
		end else begin
			ea_valid_r <= ea_valid_nxt;
			ea_r <= ea_nxt;
			mem_access_r <= mem_access_nxt;
			reg_valid_r <= reg_valid_nxt;
			reg_index_r <= reg_index_nxt;
			pair_index_r <= pair_index_nxt;
			pair_access_r <= pair_access_nxt;
			short_unused_r <= short_unused_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign ea_valid = ea_valid_r;
	assign ea = ea_r;
	assign mem_access = mem_access_r;
	assign reg_valid = reg_valid_r;
	assign reg_index = reg_index_r;
	assign pair_index = pair_index_r;
	assign pair_access = pair_access_r;
	assign short_unused = short_unused_r;
endmodule

// [testbench/oag_top_asserts.sv]
// checker for the operand address unit
module oag_top_asserts (
	input wire logic core_clk, rst_n, op_valid, stack_op, ptr_sel,
	input wire oag_pkg::oag_mode_t op_mode,
	input wire logic [15:0] full_address_operand, ea, stack_pointer,
	input wire logic [15:0] base_pointer_pair, second_pointer_pair,
	input wire logic [7:0] op_byte,
	input wire logic [2:0] reg_code, reg_index,
	input wire logic ea_valid, reg_valid, short_unused
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [2:0] m;
	// stack_op wins, so a mode counts only without it
	assign m = (op_valid && !stack_op) ? op_mode : 3'h0;
	wire gap = op_byte inside {[8'h20:8'h7f]};
	wire [15:0] ptr = ptr_sel ? base_pointer_pair : second_pointer_pair;
	sequence s_short;
		m == 3'h2;
	endsequence
	direct_ea_a: assert property (m == 3'h1 |=>
		ea_valid && ea == $past(full_address_operand)) else $error("direct");
	short_ea_a: assert property (s_short ##0 !gap |=>
		ea_valid && ea == {7'h7f, $past(op_byte < 8'h20), $past(op_byte)})
		else $error("short");
	short_gap_a: assert property (s_short ##0 gap |=>
		short_unused && !ea_valid) else $error("gap");
	sfr_ea_a: assert property (m == 3'h3 |=>
		ea_valid && ea == {8'hff, $past(op_byte)}) else $error("sfr");
	reg_sel_a: assert property (m == 3'h4 |=>
		reg_valid && reg_index == $past(reg_code)) else $error("reg");
	ind_ea_a: assert property (m == 3'h5 |=>
		ea == $past(ptr)) else $error("indirect");
	based_ea_a: assert property (m == 3'h6 |=>
		ea == $past(base_pointer_pair + op_byte)) else $error("based");
	stack_ea_a: assert property (stack_op |=>
		ea_valid && ea == $past(stack_pointer)) else $error("stack");
endmodule

bind oag_top oag_top_asserts u_chk (.*);

// [testbench/oag_rf_model.sv]
// register file model holding the pointer pairs
module oag_rf_model (
	input wire logic core_clk,
	input wire logic [1:0] wr_sel,
	input wire logic [15:0] wr_data,
	output logic [15:0] second_pointer_pair,
	output logic [15:0] base_pointer_pair,
	output logic [15:0] stack_pointer
);
	// a write every edge: the bench holds select and data steady
	always_ff @(posedge core_clk) begin
		case (wr_sel)
			2'h0: second_pointer_pair <= wr_data;
			2'h1: base_pointer_pair <= wr_data;
			default: stack_pointer <= wr_data;
		endcase
	end
endmodule

// [testbench/tb_operand_address_generator.sv]
// bench for the operand address unit
module tb_operand_address_generator;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_n = 0, op_valid = 0, stack_op = 0, ptr_sel = 0;
	logic pair_form = 0, ea_valid, mem_access, reg_valid, pair_access;
	logic short_unused;
	oag_pkg::oag_mode_t op_mode = oag_pkg::OAG_MODE_NONE;
	logic [15:0] full_address_operand = 16'hbeef, wr_data = 16'h0, ea;
	logic [15:0] second_pointer_pair, base_pointer_pair, stack_pointer;
	logic [7:0] op_byte = 8'h0;
	logic [2:0] reg_code = 3'h0, reg_index;
	logic [1:0] register_pair_operand = 2'h0, wr_sel = 2'h0, pair_index;
	int mismatches = 0, n_checks = 0, cyc = 0;
	oag_top dut (.*);
	oag_rf_model rf (.*);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc > 500) begin
		mismatches++;
		print_verdict();
	end
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// flags f: pair_access, short_unused, reg_valid, ea_valid
	task automatic rq(logic [2:0] m, logic [7:0] b, logic s,
		logic [15:0] x, logic [3:0] f);
		op_valid <= 1'b1;
		op_mode <= oag_pkg::oag_mode_t'(m);
		op_byte <= b;
		stack_op <= s;
		@(posedge core_clk);
		op_valid <= 1'b0;
		stack_op <= 1'b0;
		#1;
		chk(16'({pair_access, short_unused, reg_valid, ea_valid}), 16'(f));
		// mem_access must follow ea_valid on every answer
		chk(16'(mem_access), 16'(f[0]));
		if (f[0] | f[2]) chk(ea, x);
		@(posedge core_clk);
	endtask
	task automatic ld(logic [1:0] s, logic [15:0] d);
		wr_sel <= s;
		wr_data <= d;
		@(posedge core_clk);
	endtask
	task automatic t_short();
		logic [7:0] sb [4] = '{8'h80, 8'hfe, 8'h00, 8'h1e};
		rq(3'h1, 8'h0, 1'b0, 16'hbeef, 4'h1);
		foreach (sb[i]) rq(3'h2, sb[i], 1'b0,
			{7'h7f, sb[i] < 8'h20, sb[i]}, 4'h1);
		rq(3'h2, 8'h20, 1'b0, 16'hfe20, 4'h4);
		rq(3'h0, 8'h80, 1'b0, 16'h0, 4'h0);
		$display("short test end");
	endtask
	task automatic t_sfr_reg();
		rq(3'h3, 8'h22, 1'b0, 16'hff22, 4'h1);
		rq(3'h3, 8'hff, 1'b0, 16'hffff, 4'h1);
		for (int i = 0; i < 8; i++) begin
			reg_code <= i[2:0];
			register_pair_operand <= i[1:0];
			pair_form <= i[0];
			rq(3'h4, 8'h0, 1'b0, 16'h0, {i[0], 3'h2});
			chk(16'({pair_index, reg_index}), 16'({i[1:0], i[2:0]}));
		end
		$display("register test end");
	endtask
	task automatic t_ptr();
		rq(3'h5, 8'h0, 1'b0, 16'h1234, 4'h1);
		ptr_sel <= 1'b1;
		rq(3'h5, 8'h0, 1'b0, 16'hfff8, 4'h1);
		rq(3'h6, 8'h10, 1'b0, 16'h0008, 4'h1);
		rq(3'h1, 8'h0, 1'b1, 16'hfe20, 4'h1);
		rq(3'h7, 8'h0, 1'b0, 16'hfe20, 4'h1);
		$display("pointer test end");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		ld(2'h0, 16'h1234);
		ld(2'h1, 16'hfff8);
		ld(2'h2, 16'hfe20);
		@(posedge core_clk);
		rst_n <= 1'b1;
		t_short();
		t_sfr_reg();
		t_ptr();
		print_verdict();
	end
endmodule
